// ---- logic/scr_ctrl.sv ----
/*
 * scr_ctrl: system clock and reset controller. Derives the bus clock,
 * sequences power-on, internal and pin resets, holds break and reset-cause
 * status, and latches up to 128 interrupt sources.
 * Assumes mclk_i is the oscillator reference clock; the clock generator
 * output and the reset pin arrive asynchronously; reset sources from the
 * CPU, watchdog and supervisors are on the mclk_i domain.
 */
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps

// Notes on behaviour
// - with pll_sel_i set, bus clock is the clock generator output divided by two.
// - with pll_sel_i clear, bus rate is the reference clock divided by four.
// - after power-on or low voltage, clocks stay off for 4096 cycles.
// - the reset pin is driven low through the whole stabilisation timeout.
// - bus clocks start as soon as the timeout completes.
// - break status bit 1 cleared by writing zero; resets to zero.
// - reset cause is read-only, bits 7..3 and 1 flag causes, resets to 0x80.
// - break control bit 7 is a read/write clear enable, reset zero.
// - interrupt latching is modular, extendable to 128 sources.
// - power-on sets the power-on flag and clears every other cause bit.
// - internal resets drive the pin low 32 cycles, then hold 32 more.
module scr_ctrl #(
	parameter int POR_TIMEOUT = scr_pkg::SCR_POR_TIMEOUT_CYC,   // stabilisation cycles
	parameter int NUM_SRC     = 8                               // interrupt sources
) (
	input  wire logic                  mclk_i,         // reference clock
	input  wire logic                  rst_i,          // sync reset, treated as power-on
	input  wire scr_pkg::scr_bus_req_t bus_i,          // register port request
	output logic [7:0]                 rdata_o,        // read data, cycle after strobe
	input  wire logic                  clk_gen_out_i,  // clock generator output, async
	input  wire logic                  pll_sel_i,      // 1: PLL source, 0: reference
	input  wire logic                  power_on_pulse_i, // power-on detector
	input  wire logic                  low_voltage_i,  // low-voltage detector
	input  wire logic                  watchdog_i,     // watchdog timeout
	input  wire logic                  bad_opcode_i,   // illegal opcode seen
	input  wire logic                  bad_address_i,  // illegal fetch address seen
	input  wire logic                  rst_pin_i,      // reset pin level, async
	output logic                       rst_pin_o,      // reset pin drive level
	output logic                       rst_pin_oe_o,   // reset pin drive enable
	output logic                       internal_reset_o, // reset to CPU and modules
	output logic                       bus_clk_o,      // internal bus clock
	output logic                       clk_run_o,      // internal bus clocks active
	input  wire logic                  break_wait_i,   // break hit while waiting
	input  wire logic                  break_active_i, // CPU in break state
	input  wire logic [NUM_SRC-1:0]    irq_src_i,      // interrupt requests
	input  wire logic                  irq_ack_i,      // CPU takes the vector
	output logic                       irq_req_o,      // some source pending
	output logic [6:0]                 irq_vec_o,      // lowest pending source
	output logic                       irq_o           // status interrupt, level
);
	import scr_pkg::*;

	localparam logic [SCR_CNT_W-1:0] POR_LAST  = SCR_CNT_W'(POR_TIMEOUT - 1);
	localparam logic [SCR_CNT_W-1:0] PIN_LAST  = SCR_CNT_W'(SCR_PIN_DRIVE_CYC - 1);
	localparam logic [SCR_CNT_W-1:0] TAIL_LAST = SCR_CNT_W'(SCR_RST_TAIL_CYC - 1);
	localparam logic [SCR_CNT_W-1:0] PIN_MIN   = SCR_CNT_W'(SCR_PIN_MIN_CYC - 1);

	scr_state_t             state_r, state_nxt;
	logic [SCR_CNT_W-1:0]   cnt_r, cnt_nxt;
	logic [2:0]             pin_sync_r, cgm_sync_r;
	logic                   pin_lvl_r, cgm_lvl_r, cgm_rise_r, div_ph_r;
	logic [7:0]             brk_stat_r, cause_r, brk_ctrl_r, irq_stat_r, irq_mask_r;
	logic [7:0]             ev;
	logic                   int_src, por_src, wr_brk, brk_clr_ok;
	logic [NUM_SRC-1:0]     pend_r;

	// three-stage synchronisers; a level counts once stages two and three agree
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			pin_sync_r <= 3'h7;
			cgm_sync_r <= 3'h0;
			pin_lvl_r  <= 1'b1;
			cgm_lvl_r  <= 1'b0;
			cgm_rise_r <= 1'b0;
		end else begin
			pin_sync_r <= {pin_sync_r[1:0], rst_pin_i};
			cgm_sync_r <= {cgm_sync_r[1:0], clk_gen_out_i};
			if (pin_sync_r[2] == pin_sync_r[1])
				pin_lvl_r <= pin_sync_r[2];
			if (cgm_sync_r[2] == cgm_sync_r[1])
				cgm_lvl_r <= cgm_sync_r[2];
			cgm_rise_r <= (cgm_sync_r[2] == cgm_sync_r[1]) && cgm_sync_r[2] && !cgm_lvl_r;
		end
	end

	assign por_src = power_on_pulse_i | low_voltage_i;
	assign int_src = watchdog_i | bad_opcode_i | bad_address_i;

	// reset sequencer next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r + 1'b1;
		case (state_r)
			SCR_ST_HOLD: begin
				if (cnt_r == POR_LAST) begin
					state_nxt = SCR_ST_PIN;
					cnt_nxt   = '0;
				end
			end
			SCR_ST_PIN: begin
				if (cnt_r == PIN_LAST) begin
					state_nxt = SCR_ST_TAIL;
					cnt_nxt   = '0;
				end
			end
			SCR_ST_TAIL: begin
				if (cnt_r == TAIL_LAST) begin
					state_nxt = SCR_ST_RUN;
					cnt_nxt   = '0;
				end
			end
			SCR_ST_RUN: begin
				cnt_nxt = '0;
				if (int_src) begin
					state_nxt = SCR_ST_PIN;
				end else if (!pin_lvl_r) begin
					state_nxt = SCR_ST_EXT;
				end
			end
			SCR_ST_EXT: begin
				// counter saturates so a long press cannot wrap
				if (cnt_r == PIN_MIN)
					cnt_nxt = cnt_r;
				if (pin_lvl_r) begin
					state_nxt = SCR_ST_TAIL;
					cnt_nxt   = '0;
				end
			end
			default: begin
				state_nxt = SCR_ST_HOLD;
				cnt_nxt   = '0;
			end
		endcase
		// power-on and low voltage restart the whole sequence from anywhere
		if (por_src) begin
			state_nxt = SCR_ST_HOLD;
			cnt_nxt   = '0;
		end
	end

	// sequencer state and counter
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_r <= SCR_ST_HOLD;
			cnt_r   <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// pin and reset outputs follow the next state so they line up with state_r
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rst_pin_oe_o     <= 1'b1;
			rst_pin_o        <= 1'b0;
			internal_reset_o <= 1'b1;
			clk_run_o        <= 1'b0;
		end else begin
			rst_pin_oe_o     <= (state_nxt == SCR_ST_HOLD) || (state_nxt == SCR_ST_PIN);
			rst_pin_o        <= 1'b0;
			internal_reset_o <= (state_nxt != SCR_ST_RUN);
			clk_run_o        <= (state_nxt != SCR_ST_HOLD);
		end
	end

	// bus clock: held low during the hold, else divided from the chosen source
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			bus_clk_o <= 1'b0;
			div_ph_r  <= 1'b0;
		end else if (state_nxt == SCR_ST_HOLD) begin
			bus_clk_o <= 1'b0;
			div_ph_r  <= 1'b0;
		end else begin
			div_ph_r <= ~div_ph_r;
			if (pll_sel_i) begin
				if (cgm_rise_r)
					bus_clk_o <= ~bus_clk_o;
			end else if (div_ph_r) begin
				bus_clk_o <= ~bus_clk_o;
			end
		end
	end

	assign wr_brk     = bus_i.wr && (bus_i.addr == SCR_ADDR_BREAK_STAT);
	// while in break, the flag is only clearable when software allows it
	assign brk_clr_ok = !break_active_i || brk_ctrl_r[SCR_BIT_BREAK_CLR_EN];

	// break status and break control registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			brk_stat_r <= SCR_RST_BREAK_STAT;
			brk_ctrl_r <= SCR_RST_BREAK_CTRL;
		end else begin
			if (break_wait_i)
				brk_stat_r[SCR_BIT_BREAK_WAIT] <= 1'b1;
			else if (wr_brk && !bus_i.wdata[SCR_BIT_BREAK_WAIT] && brk_clr_ok)
				brk_stat_r[SCR_BIT_BREAK_WAIT] <= 1'b0;
			if (bus_i.wr && (bus_i.addr == SCR_ADDR_BREAK_CTRL))
				brk_ctrl_r[SCR_BIT_BREAK_CLR_EN] <= bus_i.wdata[SCR_BIT_BREAK_CLR_EN];
		end
	end

	// reset cause: each new reset replaces the previous record, except a pin press released before cnt_r reaches PIN_MIN
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			cause_r <= SCR_RST_RESET_CAUSE;
		end else if (power_on_pulse_i) begin
			cause_r <= SCR_RST_RESET_CAUSE;
		end else if (low_voltage_i) begin
			cause_r <= 8'h02;
		end else if (state_r == SCR_ST_RUN && int_src) begin
			// cause bits, reserved bits stay zero
			cause_r <= {2'h0, watchdog_i, bad_opcode_i, bad_address_i, 3'h0};
		end else if (state_r == SCR_ST_EXT && pin_lvl_r && cnt_r == PIN_MIN) begin
			cause_r <= 8'h40;
		end
	end

	// events for the status interrupt
	always_comb begin
		ev = 8'h00;
		ev[SCR_BIT_EV_BREAK]     = break_wait_i && !brk_stat_r[SCR_BIT_BREAK_WAIT];
		ev[SCR_BIT_EV_PIN]       = (state_r == SCR_ST_EXT) && pin_lvl_r && (cnt_r == PIN_MIN);
		ev[SCR_BIT_EV_CLK_START] = (state_r == SCR_ST_HOLD) && (state_nxt == SCR_ST_PIN);
	end

	// status is cleared by a read; an event in the same cycle survives
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_stat_r <= 8'h00;
			irq_mask_r <= SCR_RST_IRQ_MASK;
			irq_o      <= 1'b0;
		end else begin
			if (bus_i.rd && bus_i.addr == SCR_ADDR_IRQ_STAT)
				irq_stat_r <= ev;
			else
				irq_stat_r <= irq_stat_r | ev;
			if (bus_i.wr && bus_i.addr == SCR_ADDR_IRQ_MASK)
				irq_mask_r <= bus_i.wdata;
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (!bus_i.rd) begin
			rdata_o <= 8'h00;
		end else if (bus_i.addr == SCR_ADDR_BREAK_STAT) begin
			rdata_o <= brk_stat_r;
		end else if (bus_i.addr == SCR_ADDR_RESET_CAUSE) begin
			rdata_o <= cause_r;
		end else if (bus_i.addr == SCR_ADDR_BREAK_CTRL) begin
			rdata_o <= brk_ctrl_r;
		end else if (bus_i.addr == SCR_ADDR_IRQ_STAT) begin
			rdata_o <= irq_stat_r;
		end else if (bus_i.addr == SCR_ADDR_IRQ_MASK) begin
			rdata_o <= irq_mask_r;
		end else begin
			rdata_o <= 8'h00;
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++) begin : g_src
			always_ff @(posedge mclk_i) begin
				if (rst_i || internal_reset_o)
					pend_r[g] <= 1'b0;
				else if (irq_src_i[g])
					pend_r[g] <= 1'b1;
				else if (irq_ack_i && irq_req_o && irq_vec_o == 7'(g))
					pend_r[g] <= 1'b0;
			end
		end
	endgenerate

	// lowest index wins; registered so the vector is stable for the CPU
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_req_o <= 1'b0;
			irq_vec_o <= 7'h00;
		end else begin
			irq_req_o <= |pend_r;
			irq_vec_o <= 7'h00;
			for (int i = NUM_SRC - 1; i >= 0; i--) begin
				if (pend_r[i])
					irq_vec_o <= 7'(i);
			end
		end
	end

	// checks
	sequence s_hold_end;
		(state_r == SCR_ST_HOLD) && (cnt_r == POR_LAST) && !por_src;
	endsequence

	a_hold_pin_low: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == SCR_ST_HOLD) |-> (rst_pin_oe_o && !rst_pin_o))
		else $error("reset pin not driven low during hold");

	a_hold_clk_off: assert property (@(posedge mclk_i) disable iff (rst_i)
		(state_r == SCR_ST_HOLD) |-> (!bus_clk_o && !clk_run_o && cnt_r <= POR_LAST))
		else $error("clocks running during hold");
	a_clk_start_now: assert property (@(posedge mclk_i) disable iff (rst_i)
		s_hold_end |=> (clk_run_o && state_r == SCR_ST_PIN))
		else $error("clocks did not start at end of timeout");
	a_pin_then_tail: assert property (@(posedge mclk_i) disable iff (rst_i)
		((state_r == SCR_ST_PIN) && cnt_r == PIN_LAST && !por_src) |=>
		(state_r == SCR_ST_TAIL && !rst_pin_oe_o && internal_reset_o))
		else $error("pin drive did not end after 32 cycles");
	a_tail_release: assert property (@(posedge mclk_i) disable iff (rst_i)
		((state_r == SCR_ST_TAIL) && cnt_r == TAIL_LAST && !por_src) |=> !internal_reset_o)
		else $error("internal reset not released after 32 cycles");
	a_pll_div_two: assert property (@(posedge mclk_i) disable iff (rst_i)
		(pll_sel_i && state_nxt != SCR_ST_HOLD && cgm_rise_r) |=> $changed(bus_clk_o))
		else $error("bus clock missed a generator edge");
	// the last toggle must itself come from the reference divider, not from a source switch
	a_osc_div_four: assert property (@(posedge mclk_i) disable iff (rst_i)
		(!pll_sel_i && !$past(pll_sel_i) && clk_run_o && $changed(bus_clk_o)) ##1 (!pll_sel_i && clk_run_o)
		|-> $stable(bus_clk_o))
		else $error("reference divide is not four");

	a_break_clear: assert property (@(posedge mclk_i) disable iff (rst_i)
		(wr_brk && !bus_i.wdata[SCR_BIT_BREAK_WAIT] && brk_clr_ok && !break_wait_i)
		|=> !brk_stat_r[SCR_BIT_BREAK_WAIT])
		else $error("break flag not cleared by write of zero");

	a_por_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
		power_on_pulse_i |=> (cause_r == SCR_RST_RESET_CAUSE))
		else $error("power-on did not leave only the power-on flag");

	a_cause_reserved: assert property (@(posedge mclk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == SCR_ADDR_RESET_CAUSE && !por_src && !int_src
		&& state_r != SCR_ST_EXT) |=> ($stable(cause_r) && cause_r[2] == 1'b0 && cause_r[0] == 1'b0))
		else $error("reset cause changed by a write");

	a_clr_en_write: assert property (@(posedge mclk_i) disable iff (rst_i)
		(bus_i.wr && bus_i.addr == SCR_ADDR_BREAK_CTRL) |=>
		(brk_ctrl_r[SCR_BIT_BREAK_CLR_EN] == $past(bus_i.wdata[SCR_BIT_BREAK_CLR_EN])))
		else $error("break clear enable not written");

	a_pin_min_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
		((state_r == SCR_ST_EXT) && pin_lvl_r && cnt_r != PIN_MIN && !por_src)
		|=> !cause_r[SCR_BIT_PIN] || $stable(cause_r))
		else $error("pin flag set on a short press");

	a_irq_pending: assert property (@(posedge mclk_i) disable iff (rst_i)
		(|pend_r) |=> irq_req_o)
		else $error("pending source not requested");

endmodule // scr_ctrl

// ---- logic/scr_pkg.sv ----
/*
 * scr_pkg: constants, register map, state codes and bus carrier for the
 * system clock and reset controller.
 * Assumes a single 10 MHz reference clock and an 8-bit register port.
 */
package scr_pkg;

	// register byte addresses
	localparam logic [15:0] SCR_ADDR_BREAK_STAT  = 16'hfe00;
	localparam logic [15:0] SCR_ADDR_RESET_CAUSE = 16'hfe01;
	localparam logic [15:0] SCR_ADDR_BREAK_CTRL  = 16'hfe03;
	localparam logic [15:0] SCR_ADDR_IRQ_STAT    = 16'hfe04;
	localparam logic [15:0] SCR_ADDR_IRQ_MASK    = 16'hfe05;

	// field positions
	localparam int SCR_BIT_BREAK_WAIT   = 1;
	localparam int SCR_BIT_BREAK_CLR_EN = 7;
	localparam int SCR_BIT_POWER_ON     = 7;
	localparam int SCR_BIT_PIN          = 6;
	localparam int SCR_BIT_WATCHDOG     = 5;
	localparam int SCR_BIT_BAD_OPCODE   = 4;
	localparam int SCR_BIT_BAD_ADDRESS  = 3;
	localparam int SCR_BIT_LOW_VOLTAGE  = 1;
	localparam int SCR_BIT_EV_BREAK     = 0;
	localparam int SCR_BIT_EV_PIN       = 1;
	localparam int SCR_BIT_EV_CLK_START = 2;

	// reset values
	localparam logic [7:0] SCR_RST_BREAK_STAT  = 8'h00;
	localparam logic [7:0] SCR_RST_RESET_CAUSE = 8'h80;
	localparam logic [7:0] SCR_RST_BREAK_CTRL  = 8'h00;
	localparam logic [7:0] SCR_RST_IRQ_MASK    = 8'h00;

	// timing, in reference clock cycles
	localparam int SCR_CLK_HZ           = 10_000_000;
	localparam int SCR_POR_TIMEOUT_CYC  = 4096;
	localparam int SCR_PIN_DRIVE_CYC    = 32;
	localparam int SCR_RST_TAIL_CYC     = 32;
	localparam int SCR_PIN_MIN_CYC      = 67;
	localparam int SCR_CNT_W            = 13;
	localparam int SCR_MAX_IRQ_SRC      = 128;

	// reset sequencer states, one-hot
	typedef enum logic [4:0] {
		SCR_ST_HOLD = 5'b00001,
		SCR_ST_PIN  = 5'b00010,
		SCR_ST_TAIL = 5'b00100,
		SCR_ST_RUN  = 5'b01000,
		SCR_ST_EXT  = 5'b10000
	} scr_state_t;

	// register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        wr;
		logic        rd;
	} scr_bus_req_t;

endpackage : scr_pkg

// ---- bench/scr_far_model.sv ----
/*
 * scr_far_model: far side of the controller, standing for the board and
 * peripherals: an outside agent that presses the reset pin, the pin's
 * pull-up, and the clock generator output.
 * Assumes the controller drives the pin open-drain (level plus enable).
 */
`timescale 1ns/1ps
module scr_far_model (
	input  wire logic       mclk_i,      // reference clock
	input  wire logic       press_go_i,  // start a pin press
	input  wire logic [7:0] press_len_i, // press length in cycles
	input  wire logic       pin_drv_i,   // controller pin level
	input  wire logic       pin_oe_i,    // controller pin enable
	output logic            pin_o,       // resolved pin level
	output logic            gen_clk_o    // clock generator output
);
	logic [7:0] press_r = 8'h00;

	// outside press: the pin is held low for the whole requested length
	always_ff @(posedge mclk_i) begin
		if (press_go_i)
			press_r <= press_len_i;
		else if (press_r != 8'h00)
			press_r <= press_r - 8'h01;
	end

	// pull-up wins only when nobody pulls the wire low
	assign pin_o = ~((pin_oe_i & ~pin_drv_i) | (press_r != 8'h00));

	// free-running generator, 8 reference periods, phase unrelated on purpose
	initial begin
		gen_clk_o = 1'b0;
		#37;
		forever #400 gen_clk_o = ~gen_clk_o;
	end
endmodule // scr_far_model

// ---- bench/scr_ctrl_tb.sv ----
/*
 * scr_ctrl_tb: self-checking bench for the clock and reset controller.
 * Assumes scr_pkg, scr_ctrl and scr_far_model are compiled first; the
 * stabilisation count is shortened so the run stays short.
 */
`timescale 1ns/1ps
module scr_ctrl_tb;
	import scr_pkg::*;
	localparam int POR_T = 16;
	logic         mclk_i, rst_i, pll_sel_i, break_wait_i, break_active_i, irq_ack_i;
	logic         rst_pin_o, rst_pin_oe_o, internal_reset_o, bus_clk_o, clk_run_o;
	logic         irq_req_o, irq_o, pin_w, gen_clk, press_go, rd_pend = 1'b0;
	logic [4:0]   rsrc;
	logic [7:0]   irq_src_i, rdata_o, press_len, pend, m;
	logic [6:0]   irq_vec_o;
	scr_bus_req_t bus_i;
	logic [7:0]   exp_q[$];
	int           failures = 0, check_count = 0, cyc = 0, off, oe, ir, bc, n, k;
	integer       seed;

	scr_ctrl #(.POR_TIMEOUT(POR_T), .NUM_SRC(8)) DUT (.mclk_i(mclk_i), .rst_i(rst_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .clk_gen_out_i(gen_clk), .pll_sel_i(pll_sel_i), .power_on_pulse_i(rsrc[0]),
		.low_voltage_i(rsrc[1]), .watchdog_i(rsrc[2]), .bad_opcode_i(rsrc[3]), .bad_address_i(rsrc[4]),
		.rst_pin_i(pin_w), .rst_pin_o(rst_pin_o), .rst_pin_oe_o(rst_pin_oe_o),
		.internal_reset_o(internal_reset_o), .bus_clk_o(bus_clk_o), .clk_run_o(clk_run_o),
		.break_wait_i(break_wait_i), .break_active_i(break_active_i), .irq_src_i(irq_src_i),
		.irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_vec_o(irq_vec_o), .irq_o(irq_o));
	scr_far_model far (.mclk_i(mclk_i), .press_go_i(press_go), .press_len_i(press_len),
		.pin_drv_i(rst_pin_o), .pin_oe_i(rst_pin_oe_o), .pin_o(pin_w), .gen_clk_o(gen_clk));

	// 10 MHz reference clock
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// a hang is cut short well beyond the expected run length
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			test_done();
		end
	end

	// read data stand only in the cycle after the strobe, so look there
	always @(posedge mclk_i) rd_pend <= bus_i.rd;
	always @(negedge mclk_i) begin
		if (rd_pend)
			chk("read data", {8'h00, exp_q.pop_front()}, {8'h00, rdata_o});
	end

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus_i.wr <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus_i.rd <= 1'b0;
	endtask

	// counts cycles with clocks off, pin driven and internal reset held
	task automatic run_seq();
		off = 0; oe = 0; ir = 0; bc = 0;
		for (int i = 0; i < 400; i++) begin
			@(negedge mclk_i);
			if (clk_run_o !== 1'b1) off++;
			if (clk_run_o !== 1'b1 && bus_clk_o !== 1'b0) bc++;
			if (rst_pin_oe_o === 1'b1 && pin_w === 1'b0) oe++;
			if (internal_reset_o !== 1'b1) break;
			ir++;
		end
	endtask

	task automatic rises(input int len, input logic [15:0] e, input string nm);
		logic prev;
		n = 0;
		@(negedge mclk_i);
		prev = bus_clk_o;
		repeat (len) begin
			@(negedge mclk_i);
			if (prev === 1'b0 && bus_clk_o === 1'b1) n++;
			prev = bus_clk_o;
		end
		chk(nm, e, n[15:0]);
	endtask

	task automatic pulse_src(input int s);
		@(posedge mclk_i);
		rsrc[s] <= 1'b1;
		@(posedge mclk_i);
		rsrc <= 5'h00;
	endtask

	task automatic brk();
		@(posedge mclk_i);
		break_wait_i <= 1'b1;
		@(posedge mclk_i);
		break_wait_i <= 1'b0;
		repeat (4) @(negedge mclk_i);
	endtask

	task automatic press(input logic [7:0] len);
		@(posedge mclk_i);
		press_go <= 1'b1;
		press_len <= len;
		@(posedge mclk_i);
		press_go <= 1'b0;
		repeat (8) @(posedge mclk_i);
		run_seq();
	endtask

	// main sequence
	initial begin
		seed = 32'h7286bd12;
		rst_i = 1'b1; bus_i = '0; pll_sel_i = 1'b0; break_wait_i = 1'b0; break_active_i = 1'b0;
		irq_ack_i = 1'b0; irq_src_i = 8'h00; rsrc = 5'h00; press_go = 1'b0; press_len = 8'h00;
		repeat (6) @(posedge mclk_i);
		rst_i <= 1'b0;
		wr(SCR_ADDR_IRQ_MASK, 8'h05);
		rd(SCR_ADDR_RESET_CAUSE, 8'h80);
		rd(SCR_ADDR_BREAK_STAT, 8'h00);
		rd(SCR_ADDR_BREAK_CTRL, 8'h00);
		rd(16'hfe02, 8'h00);
		run_seq();
		chk("pin beyond clocks off", 16'd32, 16'(oe - off));
		chk("reset beyond pin", 16'd32, 16'(ir - oe));
		chk("bus clock while off", 16'd0, bc[15:0]);
		chk("clock start irq", 16'd1, {15'd0, irq_o});
		rd(SCR_ADDR_IRQ_STAT, 8'h04);
		rd(SCR_ADDR_IRQ_STAT, 8'h00);
		repeat (2) @(negedge mclk_i);
		chk("irq cleared", 16'd0, {15'd0, irq_o});
		$display("test power-up done");
		rises(40, 16'd10, "reference bus clock");
		@(posedge mclk_i);
		pll_sel_i <= 1'b1;
		repeat (30) @(posedge mclk_i);
		rises(160, 16'd10, "generator bus clock");
		@(posedge mclk_i);
		pll_sel_i <= 1'b0;
		$display("test bus clock done");
		brk();
		chk("break irq", 16'd1, {15'd0, irq_o});
		rd(SCR_ADDR_IRQ_STAT, 8'h01);
		rd(SCR_ADDR_BREAK_STAT, 8'h02);
		wr(SCR_ADDR_BREAK_STAT, 8'hfd);
		rd(SCR_ADDR_BREAK_STAT, 8'h00);
		wr(SCR_ADDR_BREAK_STAT, 8'hff);
		rd(SCR_ADDR_BREAK_STAT, 8'h00);
		wr(SCR_ADDR_IRQ_MASK, 8'h00);
		brk();
		chk("masked irq", 16'd0, {15'd0, irq_o});
		rd(SCR_ADDR_IRQ_STAT, 8'h01);
		break_active_i <= 1'b1;
		wr(SCR_ADDR_BREAK_STAT, 8'h00);
		rd(SCR_ADDR_BREAK_STAT, 8'h02);
		wr(SCR_ADDR_BREAK_CTRL, 8'hff);
		rd(SCR_ADDR_BREAK_CTRL, 8'h80);
		wr(SCR_ADDR_BREAK_STAT, 8'h00);
		rd(SCR_ADDR_BREAK_STAT, 8'h00);
		break_active_i <= 1'b0;
		wr(SCR_ADDR_RESET_CAUSE, 8'h00);
		rd(SCR_ADDR_RESET_CAUSE, 8'h80);
		m = 8'($random(seed));
		wr(SCR_ADDR_IRQ_MASK, m);
		rd(SCR_ADDR_IRQ_MASK, m);
		wr(SCR_ADDR_IRQ_MASK, 8'h00);
		$display("test registers done");
		pend = 8'($random(seed)) | 8'h01;
		@(posedge mclk_i);
		irq_src_i <= pend;
		@(posedge mclk_i);
		irq_src_i <= 8'h00;
		repeat (3) @(posedge mclk_i);
		while (pend != 8'h00) begin
			for (k = 7; k >= 0; k--) if (pend[k]) n = k;
			@(negedge mclk_i);
			chk("irq vector", 16'(n), {9'd0, irq_vec_o});
			@(posedge mclk_i);
			irq_ack_i <= 1'b1;
			@(posedge mclk_i);
			irq_ack_i <= 1'b0;
			pend[n] = 1'b0;
			repeat (3) @(posedge mclk_i);
		end
		@(negedge mclk_i);
		chk("irq drained", 16'd0, {15'd0, irq_req_o});
		$display("test sources done");
		for (int s = 4; s >= 0; s--) begin
			pulse_src(s);
			run_seq();
			chk("clocks off", (s < 2) ? 16'(POR_T) : 16'd0, off[15:0]);
			chk("pin drive", (s < 2) ? 16'(POR_T + 32) : 16'd32, oe[15:0]);
			chk("internal reset", (s < 2) ? 16'(POR_T + 64) : 16'd64, ir[15:0]);
			rd(SCR_ADDR_RESET_CAUSE, 8'h01 << (s == 1 ? 1 : 7 - s));
		end
		$display("test internal resets done");
		press(8'd30);
		chk("short press resets", 16'd1, {15'd0, ir > 30});
		rd(SCR_ADDR_RESET_CAUSE, 8'h80);
		press(8'd90);
		rd(SCR_ADDR_RESET_CAUSE, 8'h40);
		// pin recognised plus the two clock starts left by the power-on style resets
		rd(SCR_ADDR_IRQ_STAT, 8'h06);
		$display("test pin reset done");
		repeat (4) @(posedge mclk_i);
		test_done();
	end
endmodule // scr_ctrl_tb
